// [testbench.sv]
`timescale 1ns/1ns
module testbench;
  logic        clk, arst_n, timer_tick, wr, rd;
  logic [3:0]  addr;
  logic [15:0] wdata, rdata, rv;
  logic        pa, pae, pb, pbe, ovf, lva, lvb;
  logic [2:0]  m;
  logic [1:0]  aa;
  logic [7:0]  ca, cb;
  int          n_errors, checks_done, seed, r;
  // corner cases: mode, action a, action b, compare a, compare b
  logic [22:0] corner [7] = '{{3'h3, 2'h2, 2'h3, 8'h00, 8'hFF}, {3'h3, 2'h3, 2'h2, 8'hFF, 8'h00},
    {3'h1, 2'h2, 2'h3, 8'h00, 8'hFF}, {3'h1, 2'h3, 2'h2, 8'hFF, 8'h00}, {3'h7, 2'h1, 2'h2, 8'h40, 8'h40},
    {3'h5, 2'h1, 2'h3, 8'h40, 8'h40}, {3'h1, 2'h1, 2'h2, 8'h80, 8'h7F}};

  tpw_pwm_timer i_tpw_pwm_timer (.clk(clk), .arst_n(arst_n), .timer_tick(timer_tick), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pin_a_out(pa), .pin_a_oe(pae), .pin_b_out(pb),
    .pin_b_oe(pbe), .overflow_flag(ovf));
  tpw_load i_tpw_load (.pin_a_out(pa), .pin_a_oe(pae), .pin_b_out(pb), .pin_b_oe(pbe),
    .level_a(lva), .level_b(lvb));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////
  task automatic test_done();
    if (n_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(logic [3:0] a, logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  // random ticks; each tick slot adds the pin level it shows
  task automatic run_ticks(int n, output logic [15:0] ha, hb);
    int t, cyc, q;
    t = 0;
    cyc = 0;
    ha = 16'h0000;
    hb = 16'h0000;
    while (t < n) begin
      @(posedge clk);
      q = $random(seed);
      timer_tick <= q[0];
      @(negedge clk);
      if (timer_tick) begin
        t++;
        ha = ha + {15'h0000, lva};
        hb = hb + {15'h0000, lvb};
      end
      cyc++;
      if (cyc > 8 * n + 32) begin
        n_errors++;
        test_done();
      end
    end
    @(posedge clk);
    timer_tick <= 1'b0;
  endtask

  // high tick slots over two periods
  function automatic logic [15:0] exp_high(logic [2:0] md, logic [1:0] act, logic [7:0] c, logic [7:0] top);
    logic [15:0] per, h;
    per = md[1] ? {8'h00, top} + 16'h0001 : {7'h00, top, 1'b0};
    h = md[1] ? {8'h00, c} + 16'h0001 : {7'h00, c, 1'b0};
    if (act == tpw_pkg::ACT_INV) h = per - h;
    if (act == tpw_pkg::ACT_OFF) h = 16'h0000;
    // toggle flips once a period, so two periods hold one period of high slots
    if (act == tpw_pkg::ACT_TOGGLE) return md[2] ? per : 16'h0000;
    return h + h;
  endfunction

  ////////////////////////////////////////
  // fresh reset each case so the counter starts at zero counting up
  task automatic run_case(logic [2:0] md, logic [1:0] a, logic [1:0] b, logic [7:0] x, logic [7:0] y);
    logic [7:0]  top;
    logic [15:0] ha, hb, c0;
    int          p;
    top = md[2] ? x : tpw_pkg::COUNT_FIXED_TOP;
    p = md[1] ? top + 1 : 2 * top;
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rd_reg(tpw_pkg::ADDR_STATUS, rv);
    check("wave regs after reset", rv & 16'h0018, 16'h0000);
    wr_reg(tpw_pkg::ADDR_CMP_A, {8'h00, x});
    wr_reg(tpw_pkg::ADDR_CMP_B, {8'h00, y});
    wr_reg(tpw_pkg::ADDR_CTRL, {6'h00, 2'b11, b, a, 1'b0, md});
    run_ticks(p + 3, ha, hb);
    run_ticks(2 * p, ha, hb);
    check("pin a high ticks", ha, exp_high(md, a, x, top));
    check("pin b high ticks", hb, exp_high(md, b, y, top));
    rd_reg(tpw_pkg::ADDR_STATUS, rv);
    check("overflow set", {rv[0], ovf}, 16'h0003);
    wr_reg(tpw_pkg::ADDR_STATUS, 16'h0001);
    rd_reg(tpw_pkg::ADDR_STATUS, rv);
    check("overflow cleared", rv & 16'h0001, 16'h0000);
    rd_reg(tpw_pkg::ADDR_COUNT, c0);
    wr_reg(tpw_pkg::ADDR_COUNT, ~c0);
    rd_reg(tpw_pkg::ADDR_COUNT, rv);
    check("count without tick", rv, c0);
    // a compare write while running must not reach the comparator before the reload point
    wr_reg(tpw_pkg::ADDR_STATUS, 16'h0006);
    wr_reg(tpw_pkg::ADDR_CMP_B, c0);
    run_ticks(1, ha, hb);
    rd_reg(tpw_pkg::ADDR_STATUS, rv);
    check("compare b buffered", {15'h0000, rv[2]}, {15'h0000, c0[7:0] == y});
    wr_reg(tpw_pkg::ADDR_CTRL, {6'h00, 2'b00, b, a, 1'b0, md});
    @(negedge clk);
    check("released pins", {lva, lvb, pae, pbe}, 16'h0000);
    wr_reg(tpw_pkg::ADDR_CTRL, 16'h0000);
  endtask

  initial begin
    seed = 32'h73418fbd;
    n_errors = 0;
    checks_done = 0;
    arst_n = 1'b0;
    timer_tick = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    foreach (corner[i]) run_case(corner[i][22:20], corner[i][19:18], corner[i][17:16], corner[i][15:8],
      corner[i][7:0]);
    // random modes and compares; channel b stays at or below top
    for (int k = 0; k < 8; k++) begin
      r = $random(seed);
      m = {r[1:0], 1'b1};
      ca = r[15:8] | 8'h10;
      cb = m[2] ? (r[23:16] & ca) : r[23:16];
      aa = (m[2] && r[2]) ? tpw_pkg::ACT_TOGGLE : {1'b1, r[3]};
      run_case(m, aa, {1'b1, r[4]}, ca, cb);
    end
    rd_reg(4'hF, rv);
    check("unmapped read", rv, 16'h0000);
    test_done();
  end
endmodule

// [tpw_counter.sv]
`timescale 1ns/1ns
// up or up/down counter with top selection, advances only on the tick
module tpw_counter #(
  parameter int WIDTH = 8
) (
  input  wire logic                  clk,      // system clock
  input  wire logic                  arst_n,   // asynchronous reset, active low
  input  wire logic                  tick,     // timer tick enable
  input  wire logic                  dual,     // 1 = dual slope
  input  wire logic [WIDTH-1:0]      top,      // current top value
  output logic      [WIDTH-1:0]      count,    // count value
  output logic                       dir_up,   // counting direction
  output tpw_pkg::tpw_cnt_evt_t      evt       // decoded positions
);

  logic [WIDTH-1:0] next_count;
  logic             next_dir_up;
  wire              hit_top = (count == top);
  wire              hit_bot = (count == '0);

  // next count: single slope wraps after top, dual slope turns at both ends
  always_comb begin
    next_count  = count;
    next_dir_up = dir_up;
    if (!dual) begin
      next_dir_up = 1'b1;
      next_count  = hit_top ? '0 : WIDTH'(count + 1'b1);
    end else if (dir_up) begin
      if (hit_top) begin
        next_dir_up = 1'b0;
        next_count  = WIDTH'(count - 1'b1);
      end else begin
        next_count  = WIDTH'(count + 1'b1);
      end
    end else begin
      if (hit_bot) begin
        next_dir_up = 1'b1;
        next_count  = WIDTH'(count + 1'b1);
      end else begin
        next_count  = WIDTH'(count - 1'b1);
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count  <= '0;
      dir_up <= 1'b1;
    end else if (tick) begin
      count  <= next_count;
      dir_up <= next_dir_up;
    end
  end

  assign evt.at_top      = hit_top;
  assign evt.at_bottom   = hit_bot;
  assign evt.wrap        = !dual && hit_top;
  assign evt.counting_up = dir_up;

endmodule

// [tpw_load.sv]
`timescale 1ns/1ns
// load on the two pins; a weak pull-down holds a released pin low
module tpw_load (
  input  wire logic pin_a_out, // pin a drive value
  input  wire logic pin_a_oe,  // pin a output enable
  input  wire logic pin_b_out, // pin b drive value
  input  wire logic pin_b_oe,  // pin b output enable
  output logic      level_a,   // level seen at pin a
  output logic      level_b    // level seen at pin b
);
  // a released pin shows the pull level, never the last driven value
  assign level_a = pin_a_oe ? pin_a_out : 1'b0;
  assign level_b = pin_b_oe ? pin_b_out : 1'b0;
endmodule

// [tpw_pkg.sv]
package tpw_pkg;

  // register map of the plain register port
  localparam logic [3:0] ADDR_CTRL   = 4'h0; // mode, output actions, pin directions
  localparam logic [3:0] ADDR_CMP_A  = 4'h1; // buffered compare value a
  localparam logic [3:0] ADDR_CMP_B  = 4'h2; // buffered compare value b
  localparam logic [3:0] ADDR_COUNT  = 4'h3; // count value, read only
  localparam logic [3:0] ADDR_STATUS = 4'h4; // flags, write one to clear

  // control register field positions
  localparam int CTRL_MODE_LSB  = 0;  // waveform_mode_select, 3 bits
  localparam int CTRL_ACT_A_LSB = 4;  // output_action_a, 2 bits
  localparam int CTRL_ACT_B_LSB = 6;  // output_action_b, 2 bits
  localparam int CTRL_DIR_A     = 8;  // pin a direction, 1 = output
  localparam int CTRL_DIR_B     = 9;  // pin b direction, 1 = output

  // status register field positions
  localparam int STAT_OVF  = 0;
  localparam int STAT_CMPA = 1;
  localparam int STAT_CMPB = 2;

  // reset values
  localparam logic [8:0] CTRL_RESET  = 9'h000; // same width as the control struct
  localparam logic [7:0] CMP_RESET   = 8'h00;
  localparam logic [7:0] COUNT_FIXED_TOP = 8'hFF;

  // waveform mode codes
  localparam logic [2:0] MODE_DUAL_FIXED   = 3'h1;
  localparam logic [2:0] MODE_SINGLE_FIXED = 3'h3;
  localparam logic [2:0] MODE_DUAL_CMPA    = 3'h5;
  localparam logic [2:0] MODE_SINGLE_CMPA  = 3'h7;

  // output action codes
  localparam logic [1:0] ACT_OFF    = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_NONINV = 2'h2;
  localparam logic [1:0] ACT_INV    = 2'h3;

  typedef struct packed {
    logic [2:0] mode;     // waveform_mode_select
    logic [1:0] act_a;    // output_action_a
    logic [1:0] act_b;    // output_action_b
    logic       dir_a;
    logic       dir_b;
  } tpw_ctrl_t;

  // one tick's worth of events from the counter
  typedef struct packed {
    logic       at_top;     // count equals top this tick
    logic       at_bottom;  // count equals zero this tick
    logic       wrap;       // single slope: top -> zero on this tick
    logic       counting_up;
  } tpw_cnt_evt_t;

endpackage

// [tpw_pwm_timer.sv]
`timescale 1ns/1ns
module tpw_pwm_timer #(
  parameter int WIDTH = 8
) (
  input  wire logic        clk,        // 100 MHz system clock
  input  wire logic        arst_n,     // asynchronous reset, active low
  input  wire logic        timer_tick, // one-cycle enable from the prescaler
  input  wire logic [3:0]  addr,       // register address
  input  wire logic [15:0] wdata,      // write data
  input  wire logic        wr,         // write strobe
  input  wire logic        rd,         // read strobe
  output logic      [15:0] rdata,      // read data, cycle after rd
  output logic             pin_a_out,  // pin a drive value
  output logic             pin_a_oe,   // pin a output enable
  output logic             pin_b_out,  // pin b drive value
  output logic             pin_b_oe,   // pin b output enable
  output logic             overflow_flag // sticky overflow flag
);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  tpw_pkg::tpw_ctrl_t ctrl;
  logic [7:0]  buf_a;        // software-side compare a
  logic [7:0]  buf_b;
  logic [7:0]  compare_value_a; // active compare a
  logic [7:0]  compare_value_b;
  logic        compare_flag_a;
  logic        compare_flag_b;
  logic [7:0]  count_value;
  logic        dir_up;
  logic        match_a;
  logic        match_b;
  logic        wave_output_a;
  logic        wave_output_b;
  tpw_pkg::tpw_cnt_evt_t evt;

  // address decode
  wire wr_ctrl = wr && (addr == tpw_pkg::ADDR_CTRL);
  wire wr_a    = wr && (addr == tpw_pkg::ADDR_CMP_A);
  wire wr_b    = wr && (addr == tpw_pkg::ADDR_CMP_B);
  wire wr_stat = wr && (addr == tpw_pkg::ADDR_STATUS);

  // mode decode
  wire single  = (ctrl.mode == tpw_pkg::MODE_SINGLE_FIXED) ||
                 (ctrl.mode == tpw_pkg::MODE_SINGLE_CMPA);
  wire dual    = (ctrl.mode == tpw_pkg::MODE_DUAL_FIXED) ||
                 (ctrl.mode == tpw_pkg::MODE_DUAL_CMPA);
  wire pwm_on  = single || dual;
  wire mode_high_bit = ctrl.mode[2];
  // top from compare a whenever mode bit 2 is set (modes 4 to 7), else fixed
  wire [7:0] top = mode_high_bit ? compare_value_a : tpw_pkg::COUNT_FIXED_TOP;
  wire tick    = timer_tick && pwm_on;
  // in a pwm mode, buffered compares reach the comparator only at wrap or top
  wire load_cmp = !pwm_on || (single ? evt.wrap : evt.at_top);

  ////////////////////////////////////////////////////////////////////////////
  // control and compare buffers

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl  <= tpw_pkg::tpw_ctrl_t'(tpw_pkg::CTRL_RESET);
      buf_a <= tpw_pkg::CMP_RESET;
      buf_b <= tpw_pkg::CMP_RESET;
    end else begin
      if (wr_ctrl)
        ctrl <= tpw_pkg::tpw_ctrl_t'({wdata[tpw_pkg::CTRL_MODE_LSB +: 3],
                                      wdata[tpw_pkg::CTRL_ACT_A_LSB +: 2],
                                      wdata[tpw_pkg::CTRL_ACT_B_LSB +: 2],
                                      wdata[tpw_pkg::CTRL_DIR_A],
                                      wdata[tpw_pkg::CTRL_DIR_B]});
      if (wr_a)
        buf_a <= wdata[7:0];
      if (wr_b)
        buf_b <= wdata[7:0];
    end
  end

  // active compare registers; outside pwm they follow writes directly
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      compare_value_a <= tpw_pkg::CMP_RESET;
      compare_value_b <= tpw_pkg::CMP_RESET;
    end else if (!pwm_on || (tick && load_cmp)) begin
      compare_value_a <= buf_a;
      compare_value_b <= buf_b;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter and outputs

  tpw_counter #(.WIDTH(8)) u_counter (
    .clk    (clk),
    .arst_n (arst_n),
    .tick   (tick),
    .dual   (dual),
    .top    (top),
    .count  (count_value),
    .dir_up (dir_up),
    .evt    (evt)
  );

  tpw_wave_out #(.CAN_TOGGLE(1'b1)) u_wave_a (
    .clk     (clk),
    .arst_n  (arst_n),
    .tick    (tick),
    .pwm_on  (pwm_on),
    .dual    (dual),
    .mode_hi (mode_high_bit),
    .action  (ctrl.act_a),
    .count   (count_value),
    .cmp     (compare_value_a),
    .top     (top),
    .evt     (evt),
    .dir     (ctrl.dir_a),
    .match   (match_a),
    .wave    (wave_output_a),
    .pin_out (pin_a_out),
    .pin_oe  (pin_a_oe)
  );

  // output b has no toggle option
  tpw_wave_out #(.CAN_TOGGLE(1'b0)) u_wave_b (
    .clk     (clk),
    .arst_n  (arst_n),
    .tick    (tick),
    .pwm_on  (pwm_on),
    .dual    (dual),
    .mode_hi (mode_high_bit),
    .action  (ctrl.act_b),
    .count   (count_value),
    .cmp     (compare_value_b),
    .top     (top),
    .evt     (evt),
    .dir     (ctrl.dir_b),
    .match   (match_b),
    .wave    (wave_output_b),
    .pin_out (pin_b_out),
    .pin_oe  (pin_b_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  // flags: set wins over a software clear in the same cycle

  wire set_ovf  = tick && (single ? evt.at_top : (evt.at_bottom && !dir_up));
  wire set_cmpa = tick && match_a;
  wire set_cmpb = tick && match_b;
  wire clr_ovf  = wr_stat && wdata[tpw_pkg::STAT_OVF];
  wire clr_cmpa = wr_stat && wdata[tpw_pkg::STAT_CMPA];
  wire clr_cmpb = wr_stat && wdata[tpw_pkg::STAT_CMPB];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      overflow_flag  <= 1'b0;
      compare_flag_a <= 1'b0;
      compare_flag_b <= 1'b0;
    end else begin
      overflow_flag  <= set_ovf  || (overflow_flag  && !clr_ovf);
      compare_flag_a <= set_cmpa || (compare_flag_a && !clr_cmpa);
      compare_flag_b <= set_cmpb || (compare_flag_b && !clr_cmpb);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path, one cycle latency, unmapped reads return zero

  logic [15:0] next_rdata;
  wire  [15:0] ctrl_rd = {6'h00, ctrl.dir_b, ctrl.dir_a, ctrl.act_b, ctrl.act_a, 1'b0, ctrl.mode};
  wire  [15:0] stat_rd = {11'h000, wave_output_b, wave_output_a,
                          compare_flag_b, compare_flag_a, overflow_flag};

  always_comb begin
    unique case (addr)
      tpw_pkg::ADDR_CTRL:   next_rdata = ctrl_rd;
      tpw_pkg::ADDR_CMP_A:  next_rdata = {8'h00, buf_a};
      tpw_pkg::ADDR_CMP_B:  next_rdata = {8'h00, buf_b};
      tpw_pkg::ADDR_COUNT:  next_rdata = {8'h00, count_value};
      tpw_pkg::ADDR_STATUS: next_rdata = stat_rd;
      default:              next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      rdata <= 16'h0000;
    else if (rd)
      rdata <= next_rdata;
    else
      rdata <= 16'h0000;
  end

endmodule

// [tpw_pwm_timer_monitor.sv]
`timescale 1ns/1ns
// relations visible at the timer's ports only
module tpw_pwm_timer_monitor (
  input wire logic        clk,          // system clock
  input wire logic        arst_n,       // async reset, active low
  input wire logic        timer_tick,   // tick enable
  input wire logic [3:0]  addr,         // register address
  input wire logic [15:0] wdata,        // write data
  input wire logic        wr,           // write strobe
  input wire logic        rd,           // read strobe
  input wire logic [15:0] rdata,        // read data
  input wire logic        pin_a_out,    // pin a value
  input wire logic        pin_a_oe,     // pin a enable
  input wire logic        pin_b_out,    // pin b value
  input wire logic        pin_b_oe,     // pin b enable
  input wire logic        overflow_flag // sticky flag
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // decoded writes shared by several properties
  wire ctrl_wr  = wr && (addr == tpw_pkg::ADDR_CTRL);
  wire stat_clr = wr && (addr == tpw_pkg::ADDR_STATUS) && wdata[tpw_pkg::STAT_OVF];

  ////////////////////////////////////////
  property p_oe_a;
    1'b1 |=> pin_a_oe == ($past(ctrl_wr) ? $past(wdata[tpw_pkg::CTRL_DIR_A]) : $past(pin_a_oe));
  endproperty
  a_oe_a: assert property (p_oe_a) else $error("pin a enable differs from direction");
  property p_oe_b;
    1'b1 |=> pin_b_oe == ($past(ctrl_wr) ? $past(wdata[tpw_pkg::CTRL_DIR_B]) : $past(pin_b_oe));
  endproperty
  a_oe_b: assert property (p_oe_b) else $error("pin b enable differs from direction");
  // a pin may only move on a tick or a control write
  property p_tick_a;
    $changed(pin_a_out) |-> $past(timer_tick) || $past(ctrl_wr);
  endproperty
  a_tick_a: assert property (p_tick_a) else $error("pin a moved without tick");
  property p_tick_b;
    $changed(pin_b_out) |-> $past(timer_tick) || $past(ctrl_wr);
  endproperty
  a_tick_b: assert property (p_tick_b) else $error("pin b moved without tick");
  property p_ovf_rise;
    $rose(overflow_flag) |-> $past(timer_tick);
  endproperty
  a_ovf_rise: assert property (p_ovf_rise) else $error("overflow set without tick");
  property p_ovf_fall;
    $fell(overflow_flag) |-> $past(stat_clr);
  endproperty
  a_ovf_fall: assert property (p_ovf_fall) else $error("overflow lost without clear");
  property p_ovf_hold;
    overflow_flag && !stat_clr |=> overflow_flag;
  endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("overflow not sticky");
  property p_act_off_a;
    ctrl_wr && wdata[tpw_pkg::CTRL_ACT_A_LSB +: 2] == tpw_pkg::ACT_OFF |=> !pin_a_out;
  endproperty
  a_act_off_a: assert property (p_act_off_a) else $error("pin a driven with action off");
  property p_rd_idle;
    !rd |=> rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
endmodule

bind tpw_pwm_timer tpw_pwm_timer_monitor i_tpw_pwm_timer_monitor (
  .clk(clk), .arst_n(arst_n), .timer_tick(timer_tick), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe), .pin_b_out(pin_b_out),
  .pin_b_oe(pin_b_oe), .overflow_flag(overflow_flag));

// [tpw_wave_out.sv]
`timescale 1ns/1ns
// one waveform output register with its set/clear/toggle decision
module tpw_wave_out #(
  parameter bit CAN_TOGGLE = 1'b1
) (
  input  wire logic                  clk,       // system clock
  input  wire logic                  arst_n,    // asynchronous reset, active low
  input  wire logic                  tick,      // timer tick enable
  input  wire logic                  pwm_on,    // a pwm mode is selected
  input  wire logic                  dual,      // dual slope mode
  input  wire logic                  mode_hi,   // mode_high_bit
  input  wire logic [1:0]            action,    // output_action_select
  input  wire logic [7:0]            count,     // count value
  input  wire logic [7:0]            cmp,       // active compare value
  input  wire logic [7:0]            top,       // current top
  input  wire tpw_pkg::tpw_cnt_evt_t evt,       // counter positions
  input  wire logic                  dir,       // pin direction, 1 = output
  output logic                       match,     // compare equality this tick
  output logic                       wave,      // internal wave_output_n
  output logic                       pin_out,   // pin drive value
  output logic                       pin_oe     // pin output enable
);

  logic next_wave;
  logic up_level;   // level after an up-count match in dual slope
  wire  is_eq    = (count == cmp);
  wire  inv      = (action == tpw_pkg::ACT_INV);
  wire  pwm_act  = action[1];
  wire  tog_ok   = CAN_TOGGLE && mode_hi && (action == tpw_pkg::ACT_TOGGLE);
  // an equality at top is ignored when the upper action bit is set
  wire  eq_used  = is_eq && !(pwm_act && (cmp == top));

  assign match   = is_eq;
  assign up_level = inv;

  // output decision, evaluated only on ticks
  always_comb begin
    next_wave = wave;
    if (pwm_on && tog_ok && is_eq) begin
      next_wave = !wave;
    end else if (pwm_on && pwm_act && !dual) begin
      if (eq_used)
        next_wave = inv;
      else if (evt.wrap)
        next_wave = !inv;
    end else if (pwm_on && pwm_act && dual) begin
      // a zero compare meets the count only at bottom counting down, which would wrongly set the output
      if (evt.at_bottom && cmp == '0)
        next_wave = up_level;
      else if (eq_used)
        next_wave = evt.counting_up ? up_level : !up_level;
      else if (evt.at_top && cmp == top)
        next_wave = !up_level;
      else if (evt.at_bottom && !evt.counting_up && cmp != '0)
        next_wave = !up_level;                             // missed down-count equality
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      wave <= 1'b0;
    else if (tick)
      wave <= next_wave;
  end

  // pin is overridden when an action is selected, driven only as output
  assign pin_oe  = dir;
  assign pin_out = (action != tpw_pkg::ACT_OFF) ? wave : 1'b0;

endmodule
